// [csh_pkg.sv]
// Shared constants and carrier types for the component sorter handler port.
// Assumes a 32-bit AXI4-Lite register bus and a 50 MHz system clock.
package csh_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h04;
   localparam logic [7:0] OFF_LEVEL = 8'h08;
   localparam logic [7:0] OFF_LIST = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFF_KEY = 8'h1C;

   // ==========================================================
   // Field positions
   localparam int CTRL_LIST_MODE = 0;
   localparam int CTRL_EXTERNAL_START_PULSE = 1;
   localparam int CMD_SOFT_TRIG = 0;
   localparam int CMD_ANALOG_DONE = 1;
   localparam int CMD_PUBLISH = 2;
   localparam int IRQ_START = 0;
   localparam int IRQ_ANALOG = 1;
   localparam int IRQ_DONE = 2;
   localparam int IRQ_PWRFAIL = 3;
   localparam int IRQ_KEY = 4;
   localparam int IRQ_W = 5;

   // ==========================================================
   // Reset values and codes
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   localparam logic [IRQ_W-1:0] MASK_RESET = 5'h00;
   localparam logic [3:0] BIN_NONE = 4'h0;
   localparam logic [3:0] BIN_LAST = 4'h9;
   localparam logic [3:0] BIN_AUX = 4'hA;
   localparam logic [3:0] BIN_OUT = 4'hB;
   localparam int NUM_BINS = 9;
   localparam int NUM_POINTS = 10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Measurement sequence states
   typedef enum logic [1:0] {
      CSH_IDLE = 2'b00,
      CSH_MEASURE = 2'b01,
      CSH_ANALOG = 2'b10,
      CSH_DONE = 2'b11
   } csh_state_t;

   // Level comparison result as written by firmware
   typedef struct packed {
      logic secondary_reject_flag;
      logic plo;
      logic phi;
      logic [3:0] binCode;
   } csh_level_t;

   // List sweep result: per point in/out and overall pass
   typedef struct packed {
      logic pass;
      logic [9:0] pointIn;
   } csh_list_t;

   // Handler output pins, all active low
   typedef struct packed {
      logic [8:0] binResultLineN;
      logic auxBinN;
      logic outOfBinsN;
      logic primaryHighFlagN;
      logic primaryLowFlagN;
      logic secondaryRejectFlagN;
      logic analogDoneN;
      logic measureDoneStrobeN;
      logic powerFailAlarmN;
   } csh_pins_t;

   localparam csh_pins_t PINS_IDLE = 17'h1FFFF;

   // Byte-lane merge for a register write
   function automatic logic [31:0] csh_merge(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // True for every mapped register word
   function automatic logic csh_mapped(input logic [7:0] addr);
      return (addr[1:0] == 2'h0) && (addr <= OFF_KEY);
   endfunction

endpackage

// [csh_axil_slave.sv]
// AXI4-Lite slave front end: turns bus handshakes into register strobes.
// Assumes the parent returns read data combinationally for the held read address.
module csh_axil_slave (
   // Clock and synchronised reset
   input wire logic clk,
   input wire logic rstN,
   // Write address and data channels
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // Write response channel
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read channels
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Register side
   output logic wrEn,
   output logic [7:0] wrAddr,
   output logic [31:0] wrData,
   output logic [3:0] wrStrb,
   output logic [7:0] rdAddr,
   input wire logic [31:0] rdData
);

   logic awHeld_reg;
   logic wHeld_reg;
   logic rdPend_reg;
   logic fire;

   // A write fires once both halves are held and no response is pending
   assign fire = awHeld_reg && wHeld_reg && !bvalid;

   // Write address capture, independent of write data
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         awHeld_reg <= 1'b0;
         awready <= 1'b1;
         wrAddr <= 8'h00;
      end else if (awvalid && awready) begin
         awHeld_reg <= 1'b1;
         awready <= 1'b0;
         wrAddr <= awaddr;
      end else if (fire) begin
         awHeld_reg <= 1'b0;
         awready <= 1'b1;
      end
   end

   // Write data capture
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         wHeld_reg <= 1'b0;
         wready <= 1'b1;
         wrData <= 32'h00000000;
         wrStrb <= 4'h0;
      end else if (wvalid && wready) begin
         wHeld_reg <= 1'b1;
         wready <= 1'b0;
         wrData <= wdata;
         wrStrb <= wstrb;
      end else if (fire) begin
         wHeld_reg <= 1'b0;
         wready <= 1'b1;
      end
   end

   // Register strobe and write response
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         wrEn <= 1'b0;
         bvalid <= 1'b0;
         bresp <= csh_pkg::RESP_OKAY;
      end else begin
         wrEn <= fire && csh_pkg::csh_mapped(wrAddr);
         if (fire) begin
            bvalid <= 1'b1;
            bresp <= csh_pkg::csh_mapped(wrAddr) ? csh_pkg::RESP_OKAY : csh_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Read: take address, answer one cycle later
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         arready <= 1'b1;
         rdPend_reg <= 1'b0;
         rdAddr <= 8'h00;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= csh_pkg::RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rdPend_reg <= 1'b1;
            rdAddr <= araddr;
         end else if (rdPend_reg) begin
            rdPend_reg <= 1'b0;
            rvalid <= 1'b1;
            rdata <= csh_pkg::csh_mapped(rdAddr) ? rdData : 32'h00000000;
            rresp <= csh_pkg::csh_mapped(rdAddr) ? csh_pkg::RESP_OKAY : csh_pkg::RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

endmodule

// [csh_handler_port.sv]
// Handler port of the bridge: sorting result pins, strobes, alarm, trigger and keypad lock.
// Assumes firmware on an AXI4-Lite bus writes results; handler pins are synchronous to clk.
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
module csh_handler_port (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // AXI4-Lite register bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Handler inputs (after the opto couplers, active high)
   input wire logic externalStartPulse,
   input wire logic panelLock,
   // Instrument-side inputs
   input wire logic powerLossDetect,
   input wire logic keyPress,
   input wire logic [4:0] keyCode,
   // Handler outputs (active low) and measurement start
   output csh_pkg::csh_pins_t handlerPins,
   output logic measureStart,
   // Interrupt
   output logic irq
);

   // ==========================================================
   // Reset synchroniser
   logic rstMeta_reg;
   logic rstSync_reg;

   // Asynchronous assert, synchronous release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_reg <= 1'b0;
         rstSync_reg <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rstSync_reg <= rstMeta_reg;
      end
   end

   // ==========================================================
   // Bus front end
   logic wrEn;
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic [7:0] rdAddr;
   logic [31:0] rdData;

   csh_axil_slave u_slave (
      .clk(clk),
      .rstN(rstSync_reg),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .wrEn(wrEn),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .wrStrb(wrStrb),
      .rdAddr(rdAddr),
      .rdData(rdData)
   );

   // ==========================================================
   // Configuration and result registers
   logic [31:0] ctrl_reg;
   csh_pkg::csh_level_t level_reg;
   csh_pkg::csh_list_t list_reg;
   logic [csh_pkg::IRQ_W-1:0] irqMask_reg;
   logic listMode;
   logic extTrigMode;
   logic wrCmd;

   assign listMode = ctrl_reg[csh_pkg::CTRL_LIST_MODE];
   assign extTrigMode = ctrl_reg[csh_pkg::CTRL_EXTERNAL_START_PULSE];
   assign wrCmd = wrEn && (wrAddr == csh_pkg::OFF_CMD) && wrStrb[0];

   // Control: comparison mode and trigger source
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         ctrl_reg <= csh_pkg::CTRL_RESET;
      end else if (wrEn && wrAddr == csh_pkg::OFF_CTRL) begin
         ctrl_reg <= csh_pkg::csh_merge(ctrl_reg, wrData, wrStrb) & 32'h00000003;
      end
   end

   // Level and list results staged by firmware before publishing
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         level_reg <= '0;
         list_reg <= '0;
      end else if (wrEn && wrAddr == csh_pkg::OFF_LEVEL && wrStrb[0]) begin
         level_reg <= wrData[6:0];
      end else if (wrEn && wrAddr == csh_pkg::OFF_LIST) begin
         list_reg <= 11'(csh_pkg::csh_merge({21'h000000, list_reg}, wrData, wrStrb));
      end
   end

   // Interrupt mask
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         irqMask_reg <= csh_pkg::MASK_RESET;
      end else if (wrEn && wrAddr == csh_pkg::OFF_IRQ_MASK && wrStrb[0]) begin
         irqMask_reg <= wrData[csh_pkg::IRQ_W-1:0];
      end
   end

   // ==========================================================
   // Trigger detection and measurement sequence
   logic extPrev_reg;
   logic extRise;
   logic trigReq;
   logic trigAccept;
   logic analogAccept;
   logic publishAccept;
   csh_pkg::csh_state_t state_reg;

   // Rising edge of the external trigger; width is the handler's concern
   assign extRise = externalStartPulse && !extPrev_reg;
   assign trigReq = extTrigMode ? extRise : (wrCmd && wrData[csh_pkg::CMD_SOFT_TRIG]);
   assign trigAccept = trigReq && (state_reg == csh_pkg::CSH_IDLE || state_reg == csh_pkg::CSH_DONE);
   assign analogAccept = wrCmd && wrData[csh_pkg::CMD_ANALOG_DONE] && (state_reg == csh_pkg::CSH_MEASURE);
   assign publishAccept = wrCmd && wrData[csh_pkg::CMD_PUBLISH]
                          && (state_reg == csh_pkg::CSH_MEASURE || state_reg == csh_pkg::CSH_ANALOG);

   // Previous trigger level
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         extPrev_reg <= 1'b0;
      end else begin
         extPrev_reg <= externalStartPulse;
      end
   end

   // Sequence: start, analog phase done, results published
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         state_reg <= csh_pkg::CSH_IDLE;
      end else begin
         case (state_reg)
            csh_pkg::CSH_IDLE: begin
               if (trigAccept) begin
                  state_reg <= csh_pkg::CSH_MEASURE;
               end
            end
            csh_pkg::CSH_MEASURE: begin
               if (publishAccept) begin
                  state_reg <= csh_pkg::CSH_DONE;
               end else if (analogAccept) begin
                  state_reg <= csh_pkg::CSH_ANALOG;
               end
            end
            csh_pkg::CSH_ANALOG: begin
               if (publishAccept) begin
                  state_reg <= csh_pkg::CSH_DONE;
               end
            end
            csh_pkg::CSH_DONE: begin
               if (trigAccept) begin
                  state_reg <= csh_pkg::CSH_MEASURE;
               end
            end
            default: begin
               state_reg <= csh_pkg::CSH_IDLE;
            end
         endcase
      end
   end

   // One-cycle start pulse to the measurement engine
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         measureStart <= 1'b0;
      end else begin
         measureStart <= trigAccept;
      end
   end

   // ==========================================================
   // Comparison result mapping
   logic [8:0] binNext;
   logic auxNext;
   logic outNext;
   logic [3:0] code;

   assign code = level_reg.binCode;

   // Bin lines: one bin code in level mode, one sweep point each in list mode
   generate
      for (genvar i = 0; i < csh_pkg::NUM_BINS; i++) begin : g_bin
         assign binNext[i] = listMode ? list_reg.pointIn[i]
                                      : (code == 4'(i + 1));
      end
   endgenerate

   // Aux carries point ten in list mode; out line is fail in list mode
   assign auxNext = listMode ? list_reg.pointIn[csh_pkg::NUM_POINTS-1] : (code == csh_pkg::BIN_AUX);
   assign outNext = listMode ? !list_reg.pass
                             : (code == csh_pkg::BIN_OUT || level_reg.phi || level_reg.plo);

   // ==========================================================
   // Handler pins
   logic [csh_pkg::IRQ_W-1:0] irqStat_reg;

   // Result lines change only when results are published
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         handlerPins.binResultLineN <= csh_pkg::PINS_IDLE.binResultLineN;
         handlerPins.auxBinN <= 1'b1;
         handlerPins.outOfBinsN <= 1'b1;
         handlerPins.primaryHighFlagN <= 1'b1;
         handlerPins.primaryLowFlagN <= 1'b1;
         handlerPins.secondaryRejectFlagN <= 1'b1;
      end else if (publishAccept) begin
         handlerPins.binResultLineN <= ~binNext;
         handlerPins.auxBinN <= ~auxNext;
         handlerPins.outOfBinsN <= ~outNext;
         handlerPins.primaryHighFlagN <= ~(level_reg.phi && !listMode);
         handlerPins.primaryLowFlagN <= ~(level_reg.plo && !listMode);
         handlerPins.secondaryRejectFlagN <= ~(level_reg.secondary_reject_flag && !listMode);
      end
   end

   // Analog-done: low from end of analog phase until the next trigger
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         handlerPins.analogDoneN <= 1'b1;
      end else if (trigAccept) begin
         handlerPins.analogDoneN <= 1'b1;
      end else if (analogAccept || publishAccept) begin
         handlerPins.analogDoneN <= 1'b0;
      end
   end

   // Measurement-done: low one cycle after results settle, until next trigger
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         handlerPins.measureDoneStrobeN <= 1'b1;
      end else if (trigAccept) begin
         handlerPins.measureDoneStrobeN <= 1'b1;
      end else if (state_reg == csh_pkg::CSH_DONE) begin
         handlerPins.measureDoneStrobeN <= 1'b0;
      end
   end

   // Alarm follows the sticky power-fail flag until software clears it
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         handlerPins.powerFailAlarmN <= 1'b1;
      end else begin
         handlerPins.powerFailAlarmN <= ~(irqStat_reg[csh_pkg::IRQ_PWRFAIL] || powerLossDetect);
      end
   end

   // ==========================================================
   // Keypad with panel lock
   logic keyAccept;
   logic [4:0] key_reg;

   assign keyAccept = keyPress && !panelLock;

   // Last accepted key code
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         key_reg <= 5'h00;
      end else if (keyAccept) begin
         key_reg <= keyCode;
      end
   end

   // ==========================================================
   // Interrupt status and output
   logic [csh_pkg::IRQ_W-1:0] irqSet;
   logic [csh_pkg::IRQ_W-1:0] irqClr;

   assign irqSet = {keyAccept, powerLossDetect, publishAccept, analogAccept, trigAccept};
   assign irqClr = (wrEn && wrAddr == csh_pkg::OFF_IRQ_STAT && wrStrb[0]) ? wrData[csh_pkg::IRQ_W-1:0]
                                                                        : 5'h00;

   // Sticky status, write one to clear; a set in the same cycle wins
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         irqStat_reg <= 5'h00;
      end else begin
         irqStat_reg <= (irqStat_reg & ~irqClr) | irqSet;
      end
   end

   // Level interrupt while any unmasked status bit is set
   always_ff @(posedge clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((irqStat_reg & ~irqClr) | irqSet) & irqMask_reg);
      end
   end

   // ==========================================================
   // Read mux
   always_comb begin
      rdData = 32'h00000000;
      case (rdAddr)
         csh_pkg::OFF_CTRL: rdData = ctrl_reg;
         csh_pkg::OFF_LEVEL: rdData = {25'h0000000, level_reg};
         csh_pkg::OFF_LIST: rdData = {21'h000000, list_reg};
         csh_pkg::OFF_STATUS: rdData = {5'h00, handlerPins, 5'h00, externalStartPulse,
                                        powerLossDetect, panelLock, state_reg};
         csh_pkg::OFF_IRQ_STAT: rdData = {27'h0000000, irqStat_reg};
         csh_pkg::OFF_IRQ_MASK: rdData = {27'h0000000, irqMask_reg};
         csh_pkg::OFF_KEY: rdData = {27'h0000000, key_reg};
         default: rdData = 32'h00000000;
      endcase
   end

endmodule

// [csh_handler_port_sva.sv]
// Checker for the handler port pins, strobes and alarm.
// Bound to csh_handler_port; sees its ports only.
module csh_handler_port_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Observed ports
   input wire logic powerLossDetect,
   input wire logic measureStart,
   input wire csh_pkg::csh_pins_t handlerPins
);
   logic eomN;
   logic [13:0] res;
   // ====================
   // Aliases for the result lines and end strobe
   assign eomN = handlerPins.measureDoneStrobeN;
   assign res = handlerPins[16:3];
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ====================
   // Pin relations
   start_pulse_a: assert property (measureStart |=> !measureStart) else $error("start too long");
   strobe_clear_a: assert property (measureStart |-> eomN && handlerPins.analogDoneN) else $error("strobe kept");
   eom_after_a: assert property ($fell(eomN) |-> $stable(res)) else $error("done before results");
   result_hold_a: assert property (!eomN && $past(!eomN) |-> $stable(res)) else $error("results moved");
   res_publish_a: assert property (!$stable(res) |=> $fell(eomN)) else $error("results without done");
   analog_first_a: assert property ($fell(eomN) |-> !handlerPins.analogDoneN) else $error("no analog");
   alarm_on_a: assert property (powerLossDetect |-> ##[1:2] !handlerPins.powerFailAlarmN) else $error("no alarm");
   high_out_a: assert property (!handlerPins.primaryHighFlagN |-> !handlerPins.outOfBinsN) else $error("high");
   low_out_a: assert property (!handlerPins.primaryLowFlagN |-> !handlerPins.outOfBinsN) else $error("low");
   cover property ($fell(eomN));
   cover property (!handlerPins.powerFailAlarmN);
   cover property (!handlerPins.primaryHighFlagN);
endmodule

// [csh_handler_model.sv]
// Handler model: fires external start pulses, latches results.
// Assumes one clk; fire is a one-cycle request from the bench.
module csh_handler_model #(parameter int PULSE_CYC = 50) (
   // Clock and request
   input wire logic clk,
   input wire logic fire,
   // Handler pins
   input wire csh_pkg::csh_pins_t handlerPins,
   output logic externalStartPulse,
   output logic [13:0] seenRes
);
   int cnt = 0;
   // Pulse held at least 1 us, low between pulses
   always_ff @(posedge clk) begin
      if (fire) cnt <= PULSE_CYC;
      else if (cnt > 0) cnt <= cnt - 1;
   end
   assign externalStartPulse = (cnt > 0);
   // Results taken only while the end strobe is low
   always_ff @(posedge clk) begin
      if (!handlerPins.measureDoneStrobeN) seenRes <= handlerPins[16:3];
   end
endmodule

// [tb_top.sv]
// Self-checking bench for csh_handler_port.
// Assumes the AXI4-Lite timing and register map of the design package.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, awv, wv, bready, arv, rready, ext, panelLock, pwr, keyPress, fire;
   logic awready, wready, bvalid, arready, rvalid, measureStart, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [4:0] keyCode;
   logic [1:0] bresp, rresp, rs, br;
   logic [13:0] seenRes;
   logic [13:0] expQ[$];
   logic eomPrev = 1'b1;
   csh_pkg::csh_pins_t pins;
   int errors = 0;
   int checks = 0;
   integer seed = 32'h7f93;
   // ====================
   // Clock, design and handler model
   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   csh_handler_port uut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .externalStartPulse(ext), .panelLock(panelLock),
      .powerLossDetect(pwr), .keyPress(keyPress), .keyCode(keyCode), .handlerPins(pins),
      .measureStart(measureStart), .irq(irq));
   csh_handler_model #(.PULSE_CYC(50)) partner (.clk(clk), .fire(fire), .handlerPins(pins),
      .externalStartPulse(ext), .seenRes(seenRes));
   // ====================
   // Compare, verdict and bounded waits
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic tout(input int n);
      if (n >= 200) begin
         errors++;
         end_sim();
      end
   endtask
   // ====================
   // Bus cycles
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int n;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awv <= 1;
      wv <= 1;
      bready <= 1;
      for (n = 0; n < 200; n++) begin
         @(posedge clk);
         if (awready) awv <= 0;
         if (wready) wv <= 0;
         if (bvalid) break;
      end
      br = bresp;
      bready <= 0;
      @(posedge clk);
      tout(n);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      araddr <= a;
      arv <= 1;
      rready <= 1;
      for (n = 0; n < 200; n++) begin
         @(posedge clk);
         if (arready) arv <= 0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 0;
      @(posedge clk);
      tout(n);
   endtask
   // Expected result lines {bins, aux, out, high, low, secondary_reject_flag}
   function automatic logic [13:0] expRes(input bit list, input logic [31:0] x);
      logic [8:0] b;
      if (list) return {~x[8:0], ~x[9], x[10], 3'h7};
      b = 9'h1FF;
      if (x[3:0] >= 1 && x[3:0] <= 9) b[x[3:0] - 1] = 0;
      return {b, x[3:0] != 4'hA, !(x[4] | x[5]) && x[3:0] != 4'hB, ~x[4], ~x[5], ~x[6]};
   endfunction
   // One trigger, analog done, publish cycle
   task automatic meas(input bit list, input bit useExt, input logic [31:0] val);
      int n;
      axw(list ? csh_pkg::OFF_LIST : csh_pkg::OFF_LEVEL, val);
      if (useExt) begin
         for (n = 0; n < 200 && ext; n++) @(posedge clk);
         tout(n);
         fire <= 1;
         @(posedge clk);
         fire <= 0;
         for (n = 0; n < 200 && !measureStart; n++) @(posedge clk);
         tout(n);
         chk(measureStart, 1);
      end
      else axw(csh_pkg::OFF_CMD, 32'h1);
      axw(csh_pkg::OFF_CMD, 32'h2);
      repeat (2) @(posedge clk);
      chk(pins.analogDoneN, 0);
      expQ.push_back(expRes(list, val));
      axw(csh_pkg::OFF_CMD, 32'h4);
      for (n = 0; n < 200 && pins.measureDoneStrobeN; n++) @(posedge clk);
      tout(n);
      @(posedge clk);
      chk(seenRes, expRes(list, val));
   endtask
   // Result monitor: oldest note against the lines at each end strobe
   initial forever begin
      @(posedge clk);
      if (eomPrev && !pins.measureDoneStrobeN && expQ.size() > 0) chk(pins[16:3], expQ.pop_front());
      eomPrev = pins.measureDoneStrobeN;
   end
   // ====================
   // Main sequence
   initial begin
      {rst_n, awv, wv, bready, arv, rready, panelLock, pwr, keyPress, fire} = '0;
      {awaddr, araddr, wdata, wstrb, keyCode} = '0;
      repeat (20) @(posedge clk);
      rst_n <= 1;
      repeat (3) @(posedge clk);
      chk(pins, csh_pkg::PINS_IDLE);
      axw(csh_pkg::OFF_IRQ_MASK, 32'h4);
      chk(br, csh_pkg::RESP_OKAY);
      axw(8'h20, 32'h1);
      chk(br, csh_pkg::RESP_SLVERR);
      axr(csh_pkg::OFF_IRQ_MASK, rd, rs);
      chk(rd, 32'h4);
      axr(8'h20, rd, rs);
      chk(rs, csh_pkg::RESP_SLVERR);
      $display("register test done");
      for (int c = 0; c < 12; c++) meas(0, 0, ($random(seed) & 32'h70) | c);
      chk(irq, 1);
      axw(csh_pkg::OFF_IRQ_STAT, 32'h1F);
      repeat (2) @(posedge clk);
      chk(irq, 0);
      $display("level test done");
      axw(csh_pkg::OFF_CTRL, 32'h3);
      repeat (4) meas(1, 1, $random(seed) & 32'h7FF);
      $display("list test done");
      pwr <= 1;
      repeat (3) @(posedge clk);
      chk(pins.powerFailAlarmN, 0);
      pwr <= 0;
      axw(csh_pkg::OFF_IRQ_STAT, 32'h1F);
      repeat (2) @(posedge clk);
      chk(pins.powerFailAlarmN, 1);
      chk(irq, 0);
      $display("alarm test done");
      for (int k = 0; k < 2; k++) begin
         panelLock <= k[0];
         keyCode <= k ? 5'h15 : 5'h0A;
         repeat (4) @(posedge clk);
         keyPress <= 1;
         @(posedge clk);
         keyPress <= 0;
      end
      repeat (4) @(posedge clk);
      axr(csh_pkg::OFF_KEY, rd, rs);
      chk(rd, 32'hA);
      $display("key test done");
      end_sim();
   end
endmodule
bind csh_handler_port csh_handler_port_sva chk0 (.clk(clk), .rst_n(rst_n), .powerLossDetect(powerLossDetect),
   .measureStart(measureStart), .handlerPins(handlerPins));
